//--- rtl/sys_ctrl_pkg.sv
package sys_ctrl_pkg;

    // ==========================================================
    // register map and fields
    // ==========================================================
    localparam logic [31:0] FLASH_CFG_ADDR = 32'h4003C010;
    localparam logic [31:0] PART_ID_ADDR = 32'h400483F4;
    localparam logic [31:0] PWR_CFG_ADDR = 32'h40048238;
    localparam logic [31:0] SLEEP_CFG_ADDR = 32'h40048230;
    localparam logic [31:0] BOD_CTRL_ADDR = 32'h40048150;
    localparam logic [31:0] MODE_CTRL_ADDR = 32'h40038000;
    localparam logic [31:0] STATUS_ADDR = 32'h40048154;
    localparam logic [31:0] SW_RESET_ADDR = 32'h40048158;
    localparam logic [1:0] WAIT_RESET = 2'h2;
    localparam logic [1:0] WAIT_RSVD = 2'h3;
    localparam logic [29:0] FLASH_CFG_UPPER_RESET = 30'h00000000;
    localparam logic [15:0] PWR_CFG_RESET = 16'hEDF0;
    localparam logic [15:0] SLEEP_CFG_RESET = 16'hEDF8;
    localparam logic [31:0] SW_RESET_KEY = 32'h05FA0004;
    localparam int PWR_IRCOUT = 0;
    localparam int PWR_IRC = 1;
    localparam int PWR_FLASH = 2;
    localparam int PWR_BOD = 3;
    localparam int PWR_WATCHDOG_OSCILLATOR = 6;
    localparam int BOD_RST_BIT = 4;
    localparam int BOD_LVL_LSB = 2;
    localparam int WDT_LOCK_BIT = 5;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_MHZ = 50;
    localparam int IRC_START_US = 6;
    localparam int FLASH_PWR_US = 100;
    localparam int FLASH_INIT_CYC = 250;
    localparam int IRC_START_CYC = IRC_START_US * CLK_MHZ;
    localparam int FLASH_PWR_CYC = FLASH_PWR_US * CLK_MHZ;

    typedef enum logic [1:0] {
        MODE_ACTIVE = 2'h0,
        MODE_DEEPSLEEP = 2'h1,
        MODE_POWERDOWN = 2'h2,
        MODE_DEEPPD = 2'h3
    } pwr_mode_t;

    typedef enum logic [2:0] {
        SEQ_HOLD = 3'b000,
        SEQ_IRC = 3'b001,
        SEQ_FPWR = 3'b011,
        SEQ_FINIT = 3'b010,
        SEQ_RUN = 3'b110
    } seq_state_t;

    // analog power enables, one bit per block, 1 = powered
    typedef struct packed {
        logic ircOn;
        logic ircOut;
        logic flash;
        logic brownout_detector;
        logic pll;
        logic crystal;
        logic watchdog_oscillator;
        logic adc;
        logic digital;
        logic usb;
    } power_enables_t;

endpackage

//--- rtl/system_reset_power_control.sv
`timescale 1ns/1ps
// Contract
// - 32-bit read-only part identifier register, also used by programming commands.
// - Wait field bits 1:0 gives value-plus-one flash clocks; resets to 0x2.
// - Chip reset from pin, watchdog, power-on, brown-out or software request.
// - Hold internal reset until pin released, oscillator running, flash initialised.
// - Oscillator starts first; stable after at most 6 us.
// - Flash powers up about 100 us, then initialises about 250 cycles.
// - On release processor fetches from address zero, boot vector.
// - All registers hold reset values when internal reset is released.
// - Internal RC oscillator selected as system clock on reset.
// - Brown-out below selected of four levels gives interrupt or reset per select bit.
// - Brown-out interrupt signal is readable in a status register.
// - Brown-out interrupt wakes deep-sleep/power-down if start bit and controller enable.
// - Enabled brown-out reset wakes chip from deep-sleep or power-down.
// - Four reduced-power modes beyond active: sleep, deep-sleep, power-down, deep PD.
// - Per-mode peripheral power states follow the mode table.
// - Watchdog lock with RC source forces oscillator and output on; here only in deep-sleep and power-down, not in active.
// - Debug is not supported in any reduced-power mode.
// - Power config writes act at once; RC power-down waits for clean stop.
module system_reset_power_control
    import sys_ctrl_pkg::*;
#(
    parameter int FLASH_PWR_CYCLES = FLASH_PWR_CYC,
    parameter logic [31:0] PART_CODE = 32'h1234ABCD // arbitrary value
)(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // reset sources and status
    input wire logic resetPin_n,
    input wire logic watchdogReset,
    input wire logic brownoutLow,
    input wire logic [1:0] brownoutLevelHit,
    input wire logic ircRunning,
    input wire logic ircClockStopped,
    // wake and mode
    input wire logic sleepRequest,
    input wire logic brownoutStartEnable,
    input wire logic brownoutIrqEnabled,
    input wire logic wakeEvent,
    input wire logic watchdogLock,
    input wire logic watchdogIrcSelected,
    // flash access
    input wire logic flashReq,
    input wire logic [31:0] flashRdataIn,
    output logic flashReady,
    output logic [31:0] flashRdata,
    // outputs
    output logic coreReset_n,
    output logic [31:0] bootFetchAddr,
    output logic sysClkIsIrc,
    output logic brownoutIrq,
    output logic debugEnable,
    output logic flashInitStart,
    output power_enables_t powerEnables,
    output pwr_mode_t powerMode
);

    // ==========================================================
    // input synchronisers
    // ==========================================================
    logic [7:0] syncA;
    logic [7:0] syncB;
    always_ff @(posedge clk_sys)
    begin
        syncA <= {resetPin_n, watchdogReset, brownoutLow, brownoutLevelHit,
                  ircRunning, ircClockStopped, wakeEvent};
        syncB <= syncA;
    end
    logic pinRel, wdRst, bodLow, ircOk, ircStopped, wakeSync;
    logic [1:0] bodLvl;
    assign {pinRel, wdRst, bodLow, bodLvl, ircOk, ircStopped, wakeSync} = syncB;

    // ==========================================================
    // registers
    // ==========================================================
    logic [1:0] waitCycles;
    logic [29:0] flashCfgUpper;
    logic [15:0] pwrCfg;
    logic [15:0] sleepCfg;
    logic [7:0] bodCtrl;
    logic [1:0] modeSel;
    logic swReset;
    logic bodIrqLevel;
    logic chipReset;
    logic ircPdPending;
    seq_state_t seqState;

    logic wrFlash, wrPwr, wrSleep, wrBod, wrMode, wrSw;
    assign wrFlash = regWrite && regAddr == FLASH_CFG_ADDR;
    assign wrPwr = regWrite && regAddr == PWR_CFG_ADDR;
    assign wrSleep = regWrite && regAddr == SLEEP_CFG_ADDR;
    assign wrBod = regWrite && regAddr == BOD_CTRL_ADDR;
    assign wrMode = regWrite && regAddr == MODE_CTRL_ADDR;
    assign wrSw = regWrite && regAddr == SW_RESET_ADDR && regWdata == SW_RESET_KEY;

    // brown-out below chosen level; selected level compared to detector level
    logic bodTrip;
    assign bodTrip = bodLow && (bodLvl >= bodCtrl[BOD_LVL_LSB +: 2]);
    logic bodResetEvent;
    assign bodResetEvent = bodTrip && bodCtrl[BOD_RST_BIT];

    // flash config; all config registers reload while chip reset is active
    always_ff @(posedge clk_sys)
    begin
        if (chipReset)
        begin
            waitCycles <= WAIT_RESET;
            flashCfgUpper <= FLASH_CFG_UPPER_RESET;
        end
        else if (wrFlash)
        begin
            waitCycles <= regWdata[1:0];
            flashCfgUpper <= regWdata[31:2];
        end
    end

    // power config; RC power-down is deferred until its clock has stopped cleanly
    always_ff @(posedge clk_sys)
    begin
        if (chipReset)
        begin
            pwrCfg <= PWR_CFG_RESET;
            ircPdPending <= 1'b0;
        end
        else if (wrPwr)
        begin
            // power-up acts at once and beats a clean stop landing with the write; a power-down write lets that stop complete
            pwrCfg <= {regWdata[15:2],
                       regWdata[PWR_IRC] && (pwrCfg[PWR_IRC] || (ircPdPending && ircStopped)),
                       regWdata[0]};
            ircPdPending <= regWdata[PWR_IRC] && !pwrCfg[PWR_IRC] &&
                            !(ircPdPending && ircStopped);
        end
        else if (ircPdPending && ircStopped)
        begin
            pwrCfg[PWR_IRC] <= 1'b1;
            ircPdPending <= 1'b0;
        end
    end

    // sleep config, brown-out control and mode select
    always_ff @(posedge clk_sys)
    begin
        if (chipReset)
        begin
            sleepCfg <= SLEEP_CFG_RESET;
            bodCtrl <= 8'h00;
            modeSel <= 2'h0;
        end
        else
        begin
            if (wrSleep)
                sleepCfg <= regWdata[15:0];
            if (wrBod)
                bodCtrl <= regWdata[7:0];
            if (wrMode)
                modeSel <= regWdata[1:0];
        end
    end

    // software reset request is a one-cycle pulse into the reset merge
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            swReset <= 1'b0;
        else
            swReset <= wrSw && !chipReset;
    end

    // ==========================================================
    // reset merge and start-up sequence
    // ==========================================================
    always_ff @(posedge clk_sys)
    begin
        chipReset <= !rst_n || !pinRel || wdRst || bodResetEvent || swReset;
    end

    localparam int CNT_W = 20;
    logic [CNT_W-1:0] seqCount;
    always_ff @(posedge clk_sys)
    begin
        if (chipReset)
        begin
            seqState <= SEQ_HOLD;
            seqCount <= '0;
        end
        else
        begin
            seqCount <= seqCount + 1'b1;
            case (seqState)
                SEQ_HOLD:
                begin
                    seqState <= SEQ_IRC;
                    seqCount <= '0;
                end
                SEQ_IRC:
                    if (ircOk && seqCount >= CNT_W'(IRC_START_CYC - 1))
                    begin
                        seqState <= SEQ_FPWR;
                        seqCount <= '0;
                    end
                SEQ_FPWR:
                    if (seqCount >= CNT_W'(FLASH_PWR_CYCLES - 1))
                    begin
                        seqState <= SEQ_FINIT;
                        seqCount <= '0;
                    end
                SEQ_FINIT:
                    if (seqCount >= CNT_W'(FLASH_INIT_CYC - 1))
                        seqState <= SEQ_RUN;
                SEQ_RUN:
                    seqCount <= '0;
                default:
                    seqState <= SEQ_HOLD;
            endcase
        end
    end

    // internal reset released only with pin released and oscillator running
    always_ff @(posedge clk_sys)
    begin
        if (chipReset)
        begin
            coreReset_n <= 1'b0;
            flashInitStart <= 1'b0;
        end
        else
        begin
            coreReset_n <= seqState == SEQ_RUN && pinRel && ircOk;
            flashInitStart <= seqState == SEQ_FPWR &&
                              seqCount >= CNT_W'(FLASH_PWR_CYCLES - 1);
        end
    end

    // boot vector and clock source fixed at reset
    always_ff @(posedge clk_sys)
    begin
        if (chipReset)
        begin
            bootFetchAddr <= 32'h00000000;
            sysClkIsIrc <= 1'b1;
        end
    end

    // ==========================================================
    // brown-out interrupt and power modes
    // ==========================================================
    always_ff @(posedge clk_sys)
    begin
        if (chipReset)
        begin
            bodIrqLevel <= 1'b0;
            brownoutIrq <= 1'b0;
        end
        else
        begin
            bodIrqLevel <= bodTrip;
            brownoutIrq <= bodTrip && !bodCtrl[BOD_RST_BIT];
        end
    end

    // mode entry on sleep request; brown-out irq or other wake returns to active, except from deep power-down
    logic bodWake;
    assign bodWake = bodTrip && brownoutStartEnable && brownoutIrqEnabled;
    always_ff @(posedge clk_sys)
    begin
        if (chipReset)
            powerMode <= MODE_ACTIVE;
        else if (powerMode != MODE_ACTIVE && powerMode != MODE_DEEPPD &&
                 (bodWake || wakeSync))
            powerMode <= MODE_ACTIVE;
        else if (sleepRequest && powerMode == MODE_ACTIVE)
            powerMode <= pwr_mode_t'(modeSel);
    end

    // plain sleep is the active code with the core halted; debug off in any low mode
    always_ff @(posedge clk_sys)
    begin
        if (chipReset)
            debugEnable <= 1'b0;
        else
            debugEnable <= powerMode == MODE_ACTIVE && !sleepRequest;
    end

    // per-mode power enables; config bits are power-down bits, so invert
    logic lockIrc;
    assign lockIrc = watchdogLock && watchdogIrcSelected;
    power_enables_t next_enables;
    always_comb
    begin
        next_enables = '{ircOn: !pwrCfg[PWR_IRC], ircOut: !pwrCfg[PWR_IRCOUT],
                         flash: !pwrCfg[PWR_FLASH], brownout_detector: !pwrCfg[PWR_BOD],
                         pll: !pwrCfg[7], crystal: !pwrCfg[5], watchdog_oscillator: !pwrCfg[PWR_WATCHDOG_OSCILLATOR],
                         adc: !pwrCfg[4], digital: 1'b1, usb: !pwrCfg[10]};
        case (powerMode)
            MODE_ACTIVE:
                ; // sleep too: software configurable
            MODE_DEEPSLEEP, MODE_POWERDOWN:
            begin
                next_enables = '0;
                next_enables.ircOn = (powerMode == MODE_DEEPSLEEP) || lockIrc;
                next_enables.ircOut = lockIrc;
                next_enables.flash = powerMode == MODE_DEEPSLEEP;
                next_enables.brownout_detector = !sleepCfg[PWR_BOD];
                next_enables.watchdog_oscillator = !sleepCfg[PWR_WATCHDOG_OSCILLATOR];
            end
            default:
                next_enables = '0;
        endcase
    end
    always_ff @(posedge clk_sys)
    begin
        if (chipReset)
            powerEnables <= '{ircOn: 1'b1, ircOut: 1'b1, flash: 1'b1, brownout_detector: 1'b1,
                              default: 1'b0};
        else
            powerEnables <= next_enables;
    end

    // ==========================================================
    // flash wait-state stall
    // ==========================================================
    logic [1:0] waitCount;
    logic flashBusy;
    always_ff @(posedge clk_sys)
    begin
        if (chipReset)
        begin
            flashBusy <= 1'b0;
            waitCount <= 2'h0;
            flashReady <= 1'b0;
            flashRdata <= 32'h00000000;
        end
        else
        begin
            flashReady <= 1'b0;
            if (!flashBusy && flashReq)
            begin
                flashBusy <= 1'b1;
                waitCount <= 2'h0;
            end
            else if (flashBusy)
            begin
                waitCount <= waitCount + 2'h1;
                if (waitCount == waitCycles || waitCount == WAIT_RSVD)
                begin
                    flashBusy <= 1'b0;
                    flashReady <= 1'b1;
                    flashRdata <= flashRdataIn;
                end
            end
        end
    end

    // ==========================================================
    // read port
    // ==========================================================
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            regRdata <= 32'h00000000;
        else if (regRead)
            case (regAddr)
                FLASH_CFG_ADDR: regRdata <= {flashCfgUpper, waitCycles};
                PART_ID_ADDR: regRdata <= PART_CODE;
                PWR_CFG_ADDR: regRdata <= {16'h0000, pwrCfg};
                SLEEP_CFG_ADDR: regRdata <= {16'h0000, sleepCfg};
                BOD_CTRL_ADDR: regRdata <= {24'h000000, bodCtrl};
                MODE_CTRL_ADDR: regRdata <= {30'h00000000, modeSel};
                STATUS_ADDR: regRdata <= {29'h00000000, powerMode, bodIrqLevel};
                default: regRdata <= 32'h00000000;
            endcase
        else
            regRdata <= 32'h00000000;
    end

    // ==========================================================
    // checks
    // ==========================================================
    property p_wait_reset;
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(chipReset) |-> waitCycles == WAIT_RESET;
    endproperty
    a_wait_reset: assert property (p_wait_reset) else $error("wait reset value");

    property p_flash_latency;
        @(posedge clk_sys) disable iff (!rst_n || chipReset)
        (!flashBusy && flashReq && waitCycles == 2'h0 && !wrFlash) |=> ##1 flashReady;
    endproperty
    a_flash_latency: assert property (p_flash_latency) else $error("flash latency");

    property p_reset_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (seqState != SEQ_RUN) |=> !coreReset_n;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("early release");

    property p_pin_reset;
        @(posedge clk_sys) !pinRel |-> ##1 chipReset ##1 !coreReset_n;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset missed");

    property p_part_id;
        @(posedge clk_sys) disable iff (!rst_n)
        regRead && regAddr == PART_ID_ADDR |=> regRdata == PART_CODE;
    endproperty
    a_part_id: assert property (p_part_id) else $error("part id");

    property p_bod_irq;
        @(posedge clk_sys) disable iff (!rst_n || chipReset)
        (bodTrip && !bodCtrl[BOD_RST_BIT]) |=> brownoutIrq;
    endproperty
    a_bod_irq: assert property (p_bod_irq) else $error("bod irq");

    property p_deep_pd_off;
        @(posedge clk_sys) disable iff (!rst_n || chipReset)
        powerMode == MODE_DEEPPD |=> powerEnables == '0;
    endproperty
    a_deep_pd_off: assert property (p_deep_pd_off) else $error("deep pd power");

    property p_no_debug;
        @(posedge clk_sys) disable iff (!rst_n)
        powerMode != MODE_ACTIVE |=> !debugEnable;
    endproperty
    a_no_debug: assert property (p_no_debug) else $error("debug in low mode");

endmodule // system_reset_power_control

//--- testbench/far_side_model.sv
`timescale 1ns/1ps
// ==========================================
// oscillator and flash array stand-in
module far_side_model
    import sys_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // flash array
    input wire logic flashReq,
    input wire logic flashReady,
    input wire logic [31:0] flashWord,
    output logic [31:0] flashRdataIn,
    // oscillator
    input wire pwr_mode_t powerMode,
    output logic ircRunning,
    output logic ircClockStopped
);
    int upCount;
    logic busy;
    logic [31:0] hold;
    logic [2:0] stopLine;

    // oscillator settles well inside the start-up budget
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            upCount <= 0;
        else if (upCount < 100)
            upCount <= upCount + 1;
    end
    assign ircRunning = (upCount >= 100);

    // word stands only while an access is open; inverted otherwise so a late sample fails
    always_ff @(posedge clk_sys)
    begin
        if (flashReq)
            hold <= flashWord;
        busy <= flashReq | (busy & ~flashReady);
    end
    assign flashRdataIn = flashReq ? flashWord : (busy ? hold : ~hold);

    // clock stops a few cycles after deep-sleep, power-down or deep PD starts
    always_ff @(posedge clk_sys)
        stopLine <= {stopLine[1:0], powerMode != MODE_ACTIVE};
    assign ircClockStopped = stopLine[2];
endmodule // far_side_model

//--- testbench/system_reset_power_control_bench.sv
`timescale 1ns/1ps
// ==========================================
// bench for reset sequencing, registers and power modes
module system_reset_power_control_bench
    import sys_ctrl_pkg::*;
;
    localparam logic [31:0] CODE = 32'h5A5AC3C3; // arbitrary value
    logic clk_sys, rst_n, regWrite, regRead, resetPin_n, watchdogReset, brownoutLow;
    logic [31:0] regAddr, regWdata, regRdata, flashRdataIn, flashRdata, bootFetchAddr, flashWord;
    logic [1:0] brownoutLevelHit;
    logic ircRunning, ircClockStopped, sleepRequest, brownoutStartEnable, brownoutIrqEnabled;
    logic wakeEvent, watchdogLock, watchdogIrcSelected, flashReq, flashReady, coreReset_n;
    logic sysClkIsIrc, brownoutIrq, debugEnable, flashInitStart;
    logic rdLate = 1'b0;
    power_enables_t powerEnables;
    pwr_mode_t powerMode;
    logic [31:0] expQ[$];
    logic [31:0] flashQ[$];
    int num_errors = 0;
    int total_checks = 0;
    int initCount = 0;

    // ==========================================
    // design and far side
    system_reset_power_control #(.FLASH_PWR_CYCLES(20), .PART_CODE(CODE)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .resetPin_n(resetPin_n), .watchdogReset(watchdogReset), .brownoutLow(brownoutLow),
        .brownoutLevelHit(brownoutLevelHit), .ircRunning(ircRunning),
        .ircClockStopped(ircClockStopped), .sleepRequest(sleepRequest),
        .brownoutStartEnable(brownoutStartEnable), .brownoutIrqEnabled(brownoutIrqEnabled),
        .wakeEvent(wakeEvent), .watchdogLock(watchdogLock),
        .watchdogIrcSelected(watchdogIrcSelected), .flashReq(flashReq),
        .flashRdataIn(flashRdataIn), .flashReady(flashReady), .flashRdata(flashRdata),
        .coreReset_n(coreReset_n), .bootFetchAddr(bootFetchAddr), .sysClkIsIrc(sysClkIsIrc),
        .brownoutIrq(brownoutIrq), .debugEnable(debugEnable), .flashInitStart(flashInitStart),
        .powerEnables(powerEnables), .powerMode(powerMode));
    far_side_model model (
        .clk_sys(clk_sys), .rst_n(rst_n), .flashReq(flashReq), .flashReady(flashReady),
        .flashWord(flashWord), .flashRdataIn(flashRdataIn), .powerMode(powerMode),
        .ircRunning(ircRunning), .ircClockStopped(ircClockStopped));

    // 50 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ==========================================
    // checking
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // read data stand only in the cycle after the strobe, so look there alone
    always @(posedge clk_sys) rdLate <= regRead;
    always @(negedge clk_sys)
    begin
        if (rdLate === 1'b1 && expQ.size() > 0)
            check("read data", expQ.pop_front(), regRdata);
        if (flashReady === 1'b1 && flashQ.size() > 0)
            check("flash data", flashQ.pop_front(), flashRdata);
        if (flashInitStart === 1'b1)
            initCount++;
    end

    // ==========================================
    // drivers
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        expQ.push_back(e);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
    endtask

    // one access; latency counted in edges from the one that raises the request
    task automatic flash(input logic [1:0] w);
        logic [31:0] d;
        int n;
        d = $urandom;
        n = 0;
        flashQ.push_back(d);
        @(posedge clk_sys);
        flashReq <= 1'b1;
        flashWord <= d;
        do
        begin
            @(posedge clk_sys);
            flashReq <= 1'b0;
            #1;
            n++;
        end
        while (flashReady !== 1'b1 && n < 20);
        check("flash latency", 32'(w) + 2, n);
    endtask

    task automatic waitLow();
        int n;
        n = 0;
        while (coreReset_n !== 1'b0 && n < 12)
        begin
            step(1);
            n++;
        end
        check("core reset low", 32'h0, {31'h0, coreReset_n});
    endtask

    // the whole start-up chain must run before the core is let go
    task automatic waitRelease(input int lo, input int hi);
        int n;
        n = 0;
        while (coreReset_n !== 1'b1 && n < 3000)
        begin
            step(1);
            n++;
        end
        check("release span", 32'h1, {31'h0, n >= lo && n <= hi});
    endtask

    // sleep request stays up; the caller drops it once it has looked
    task automatic enter(input pwr_mode_t m);
        wr(MODE_CTRL_ADDR, {30'h0, m});
        @(posedge clk_sys);
        sleepRequest <= 1'b1;
        step(4);
        check("mode", m, powerMode);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard, a few times the expected run length
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        $display("watchdog expired");
        end_of_test();
    end

    // ==========================================
    // tests
    initial
    begin
        {regWrite, regRead, watchdogReset, brownoutLow, sleepRequest, flashReq} = '0;
        {brownoutStartEnable, brownoutIrqEnabled, wakeEvent, watchdogLock} = '0;
        {regAddr, regWdata, flashWord} = '0;
        watchdogIrcSelected = 1'b0;
        brownoutLevelHit = 2'h3;
        resetPin_n = 1'b1;
        rst_n = 1'b0;
        void'($urandom(32'hd77b));
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        waitRelease(570, 620);
        check("init pulses", 32'h1, initCount);
        check("boot address", 32'h0, bootFetchAddr);
        check("clock source", 32'h1, {31'h0, sysClkIsIrc});
        check("debug active", 32'h1, {31'h0, debugEnable});
        $display("test startup finished");
        rd(FLASH_CFG_ADDR, {FLASH_CFG_UPPER_RESET, WAIT_RESET});
        rd(PART_ID_ADDR, CODE);
        wr(PART_ID_ADDR, ~CODE);
        rd(PART_ID_ADDR, CODE);
        rd(PWR_CFG_ADDR, {16'h0, PWR_CFG_RESET});
        rd(32'h40048FFC, 32'h0);
        $display("test registers finished");
        for (int w = 0; w < 3; w++)
        begin
            wr(FLASH_CFG_ADDR, {FLASH_CFG_UPPER_RESET, 2'(w)});
            rd(FLASH_CFG_ADDR, {FLASH_CFG_UPPER_RESET, 2'(w)});
            repeat (2) flash(2'(w));
        end
        wr(PWR_CFG_ADDR, {16'h0, PWR_CFG_RESET & ~16'h0010});
        step(2);
        check("adc power", 32'h1, {31'h0, powerEnables.adc});
        wr(PWR_CFG_ADDR, {16'h0, PWR_CFG_RESET});
        $display("test flash and power finished");
        enter(MODE_ACTIVE);
        check("debug sleep", 32'h0, {31'h0, debugEnable});
        @(posedge clk_sys);
        sleepRequest <= 1'b0;
        // brown-out kept powered through deep-sleep so it can wake the chip
        wr(SLEEP_CFG_ADDR, {16'h0, SLEEP_CFG_RESET & ~16'h0008});
        enter(MODE_DEEPSLEEP);
        check("deep-sleep power", 32'h2C0, 32'(powerEnables));
        check("debug deep", 32'h0, {31'h0, debugEnable});
        @(posedge clk_sys);
        sleepRequest <= 1'b0;
        brownoutStartEnable <= 1'b1;
        brownoutIrqEnabled <= 1'b1;
        brownoutLow <= 1'b1;
        step(10);
        check("wake mode", MODE_ACTIVE, powerMode);
        check("brown-out irq", 32'h1, {31'h0, brownoutIrq});
        rd(STATUS_ADDR, 32'h1);
        @(posedge clk_sys);
        brownoutLow <= 1'b0;
        wr(BOD_CTRL_ADDR, 32'h10);
        @(posedge clk_sys);
        watchdogLock <= 1'b1;
        watchdogIrcSelected <= 1'b1;
        enter(MODE_POWERDOWN);
        check("power-down power", 32'h340, 32'(powerEnables));
        @(posedge clk_sys);
        {sleepRequest, watchdogLock, watchdogIrcSelected} <= 3'h0;
        brownoutLow <= 1'b1;
        waitLow();
        @(posedge clk_sys);
        brownoutLow <= 1'b0;
        waitRelease(560, 620);
        check("mode after reset", MODE_ACTIVE, powerMode);
        rd(BOD_CTRL_ADDR, 32'h0);
        rd(SLEEP_CFG_ADDR, {16'h0, SLEEP_CFG_RESET});
        $display("test modes finished");
        @(posedge clk_sys);
        watchdogReset <= 1'b1;
        step(3);
        @(posedge clk_sys);
        watchdogReset <= 1'b0;
        waitLow();
        waitRelease(560, 620);
        wr(SW_RESET_ADDR, SW_RESET_KEY ^ 32'h1);
        step(12);
        check("wrong key", 32'h1, {31'h0, coreReset_n});
        wr(SW_RESET_ADDR, SW_RESET_KEY);
        waitLow();
        waitRelease(560, 620);
        @(posedge clk_sys);
        resetPin_n <= 1'b0;
        waitLow();
        step(800);
        check("pin held", 32'h0, {31'h0, coreReset_n});
        @(posedge clk_sys);
        resetPin_n <= 1'b1;
        waitRelease(560, 620);
        enter(MODE_DEEPPD);
        check("deep pd power", 32'h0, 32'(powerEnables));
        $display("test resets finished");
        end_of_test();
    end
endmodule // system_reset_power_control_bench
